// ---- rtl/bgs_regs.v ----
// Global slope and transient assist configuration registers of the buck control logic.
// Assumes a serial port front end on clk_sys delivering one-cycle byte read and write strobes.
// Reserved bits and unmapped addresses are resolved here, so the port needs no filtering.
// How it works
// - Shutdown slope at 0x33 bits 6:4, codes 0-5 doubling, 7 is 60, reset 010.
// - Soft-start slope at 0x33 bits 2:0, codes 0-5 doubling, 6 is 60, reset 100.
// - Ramp-down slope at 0x34 bits 6:4, codes 6 and 7 both 60, reset 010.
// - Ramp-up slope at 0x34 bits 2:0, code 6 is 60, reset 100.
// - Bit 1 of 0x35 enables positive transient assist, reset on.
// - Bit 0 of 0x35 enables negative transient assist, reset on.
// - Addresses 0x36 to 0xFF are reserved with no function.
`timescale 1ns/10ps
`include "bgs_consts.vh"
module bgs_regs (
  input wire clk_sys,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire [2:0] shutdown_slope_sel,
  output wire [2:0] softstart_slope_sel,
  output wire [2:0] ramp_down_slope_sel,
  output wire [2:0] ramp_up_slope_sel,
  output reg [5:0] shutdown_rate,
  output reg [5:0] softstart_rate,
  output reg [5:0] ramp_down_rate,
  output reg [5:0] ramp_up_rate,
  output wire positive_transient_assist_en,
  output wire negative_transient_assist_en
);

  // Register state, one byte per mapped address
  reg [7:0] startup_shutdown_slope_config_ff;
  reg [7:0] ramp_up_down_slope_config_ff;
  reg [7:0] transient_assist_config_ff;

  // Next values of the register state
  reg [7:0] nxt_startup_shutdown_slope_config;
  reg [7:0] nxt_ramp_up_down_slope_config;
  reg [7:0] nxt_transient_assist_config;

  // Next read data
  reg [7:0] nxt_rdata;

  // Next decoded rates
  reg [5:0] nxt_shutdown_rate;
  reg [5:0] nxt_softstart_rate;
  reg [5:0] nxt_ramp_down_rate;
  reg [5:0] nxt_ramp_up_rate;

  // Address matches, shared by the write and read paths
  wire hit_startup_shutdown;
  wire hit_ramp_up_down;
  wire hit_transient_assist;

  // Write enables per register
  wire wr_startup_shutdown;
  wire wr_ramp_up_down;
  wire wr_transient_assist;

  // Address compare, one place for the decode of every mapped byte
  function bgs_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      bgs_hit = (addr == target);
    end
  endfunction

  // Codes 0 to 5 double; 6 and 7 give 60 where defined, else the slowest rate
  function [5:0] bgs_rate;
    input [2:0] code;
    input def6;
    input def7;
    begin
      case (code)
        3'h0: bgs_rate = `BGS_RATE_0;
        3'h1: bgs_rate = `BGS_RATE_1;
        3'h2: bgs_rate = `BGS_RATE_2;
        3'h3: bgs_rate = `BGS_RATE_3;
        3'h4: bgs_rate = `BGS_RATE_4;
        3'h5: bgs_rate = `BGS_RATE_5;
        3'h6: bgs_rate = def6 ? `BGS_RATE_60 : `BGS_RATE_0;
        default: bgs_rate = def7 ? `BGS_RATE_60 : `BGS_RATE_0;
      endcase
    end
  endfunction

  // Merge writable bits, reserved bits hold reset value
  function [7:0] bgs_merge;
    input [7:0] wdata;
    input [7:0] mask;
    input [7:0] rstv;
    begin
      bgs_merge = (wdata & mask) | (rstv & ~mask);
    end
  endfunction

  // Address decode of the three mapped bytes
  assign hit_startup_shutdown = bgs_hit(reg_addr, `BGS_ADDR_SLOPE1);
  assign hit_ramp_up_down = bgs_hit(reg_addr, `BGS_ADDR_SLOPE2);
  assign hit_transient_assist = bgs_hit(reg_addr, `BGS_ADDR_ASSIST);

  // Write enables; any other address drops the write
  assign wr_startup_shutdown = reg_wr & hit_startup_shutdown;
  assign wr_ramp_up_down = reg_wr & hit_ramp_up_down;
  assign wr_transient_assist = reg_wr & hit_transient_assist;

  // Next start-up and shutdown slopes; bits 7 and 3 pinned
  always @* begin
    if (wr_startup_shutdown) begin
      nxt_startup_shutdown_slope_config = bgs_merge(reg_wdata, `BGS_MASK_SLOPE,
        `BGS_RST_SLOPE1);
    end else begin
      nxt_startup_shutdown_slope_config = startup_shutdown_slope_config_ff;
    end
  end

  // Next ramp-up and ramp-down slopes; bits 7 and 3 pinned
  always @* begin
    if (wr_ramp_up_down) begin
      nxt_ramp_up_down_slope_config = bgs_merge(reg_wdata, `BGS_MASK_SLOPE,
        `BGS_RST_SLOPE2);
    end else begin
      nxt_ramp_up_down_slope_config = ramp_up_down_slope_config_ff;
    end
  end

  // Next assist enables; bits 7 to 2 keep their power-on pattern
  always @* begin
    if (wr_transient_assist) begin
      nxt_transient_assist_config = bgs_merge(reg_wdata, `BGS_MASK_ASSIST,
        `BGS_RST_ASSIST);
    end else begin
      nxt_transient_assist_config = transient_assist_config_ff;
    end
  end

  // Start-up and shutdown slope register
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      startup_shutdown_slope_config_ff <= `BGS_RST_SLOPE1;
    end else begin
      startup_shutdown_slope_config_ff <= nxt_startup_shutdown_slope_config;
    end
  end

  // Ramp-up and ramp-down slope register
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ramp_up_down_slope_config_ff <= `BGS_RST_SLOPE2;
    end else begin
      ramp_up_down_slope_config_ff <= nxt_ramp_up_down_slope_config;
    end
  end

  // Transient assist register
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transient_assist_config_ff <= `BGS_RST_ASSIST;
    end else begin
      transient_assist_config_ff <= nxt_transient_assist_config;
    end
  end

  // Read mux, zero outside the group
  always @* begin
    if (hit_startup_shutdown) begin
      nxt_rdata = startup_shutdown_slope_config_ff;
    end else if (hit_ramp_up_down) begin
      nxt_rdata = ramp_up_down_slope_config_ff;
    end else if (hit_transient_assist) begin
      nxt_rdata = transient_assist_config_ff;
    end else begin
      nxt_rdata = `BGS_ZERO;
    end
  end

  // Read data registered on read strobe, old value when a write shares the cycle
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `BGS_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end

  // Slope fields
  assign shutdown_slope_sel = startup_shutdown_slope_config_ff[`BGS_HI_MSB:`BGS_HI_LSB];
  assign softstart_slope_sel = startup_shutdown_slope_config_ff[`BGS_LO_MSB:`BGS_LO_LSB];
  assign ramp_down_slope_sel = ramp_up_down_slope_config_ff[`BGS_HI_MSB:`BGS_HI_LSB];
  assign ramp_up_slope_sel = ramp_up_down_slope_config_ff[`BGS_LO_MSB:`BGS_LO_LSB];

  // Transient assist enables
  assign positive_transient_assist_en = transient_assist_config_ff[`BGS_POS_BIT];
  assign negative_transient_assist_en = transient_assist_config_ff[`BGS_NEG_BIT];

  // Decoded rates; undefined codes fall back to the slowest rate
  always @* begin
    nxt_shutdown_rate = bgs_rate(shutdown_slope_sel, 1'h0, 1'h1);
    nxt_softstart_rate = bgs_rate(softstart_slope_sel, 1'h1, 1'h0);
    nxt_ramp_down_rate = bgs_rate(ramp_down_slope_sel, 1'h1, 1'h1);
    nxt_ramp_up_rate = bgs_rate(ramp_up_slope_sel, 1'h1, 1'h0);
  end

  // Rate registers, one cycle behind the fields
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_rate <= `BGS_RATE_2;
      softstart_rate <= `BGS_RATE_4;
      ramp_down_rate <= `BGS_RATE_2;
      ramp_up_rate <= `BGS_RATE_4;
    end else begin
      shutdown_rate <= nxt_shutdown_rate;
      softstart_rate <= nxt_softstart_rate;
      ramp_down_rate <= nxt_ramp_down_rate;
      ramp_up_rate <= nxt_ramp_up_rate;
    end
  end

endmodule // bgs_regs

// ---- rtl/bgs_consts.vh ----
// Constants for the global slew and transient assist register group.
// Assumes inclusion by bare name from the register bank module.
`ifndef BGS_CONSTS_VH
`define BGS_CONSTS_VH
`define BGS_ADDR_SLOPE1 8'h33
`define BGS_ADDR_SLOPE2 8'h34
`define BGS_ADDR_ASSIST 8'h35
`define BGS_RST_SLOPE1 8'h24
`define BGS_RST_SLOPE2 8'h24
`define BGS_RST_ASSIST 8'h5F
`define BGS_MASK_SLOPE 8'h77
`define BGS_MASK_ASSIST 8'h03
`define BGS_HI_MSB 6
`define BGS_HI_LSB 4
`define BGS_LO_MSB 2
`define BGS_LO_LSB 0
`define BGS_POS_BIT 1
`define BGS_NEG_BIT 0
`define BGS_ZERO 8'h00
// Slope rate codes, rate in units of 1.25 mV/us
`define BGS_RATE_0 6'h01
`define BGS_RATE_1 6'h02
`define BGS_RATE_2 6'h04
`define BGS_RATE_3 6'h08
`define BGS_RATE_4 6'h10
`define BGS_RATE_5 6'h20
`define BGS_RATE_60 6'h30
`endif

// ---- tb/bgs_host.sv ----
// Host model: issues single-byte register writes and reads.
// Assumes the bench calls wr and rd only after reset is released.
`timescale 1ns/10ps
module bgs_host (
  input wire clk_sys,
  output reg reg_wr,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Strobe held to the sampling edge, then the bus shows inverted values
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  // Data taken once the sampling edge has updated it
  task rd(input [7:0] a, output [7:0] q);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b0, ~a};
    #1 q = reg_rdata;
  endtask
endmodule // bgs_host

// ---- tb/bgs_regs_monitor.sv ----
// Checker for the slope and assist register bank.
// Assumes it is bound onto bgs_regs.
`timescale 1ns/10ps
module bgs_regs_monitor (
  input wire clk_sys,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [2:0] shutdown_slope_sel,
  input wire [2:0] softstart_slope_sel,
  input wire [2:0] ramp_down_slope_sel,
  input wire [2:0] ramp_up_slope_sel,
  input wire [5:0] shutdown_rate,
  input wire [5:0] softstart_rate,
  input wire [5:0] ramp_down_rate,
  input wire [5:0] ramp_up_rate,
  input wire positive_transient_assist_en,
  input wire negative_transient_assist_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Write decodes and field slices
  wire w3 = reg_wr && reg_addr == 8'h33, w4 = reg_wr && reg_addr == 8'h34;
  wire w5 = reg_wr && reg_addr == 8'h35;
  wire [2:0] hi = reg_wdata[6:4], lo = reg_wdata[2:0];
  a_sd_wr: assert property (w3 |=> shutdown_slope_sel == $past(hi)) else $error("sd");
  a_ss_wr: assert property (w3 |=> softstart_slope_sel == $past(lo)) else $error("ss");
  a_rd_wr: assert property (w4 |=> ramp_down_slope_sel == $past(hi)) else $error("rd");
  a_ru_wr: assert property (w4 |=> ramp_up_slope_sel == $past(lo)) else $error("ru");
  a_pos_wr: assert property (w5 |=> positive_transient_assist_en == $past(reg_wdata[1]))
    else $error("pos");
  a_neg_wr: assert property (w5 |=> negative_transient_assist_en == $past(reg_wdata[0]))
    else $error("neg");
  a_rsv_read: assert property (reg_rd && reg_addr > 8'h35 |=> reg_rdata == 8'h00)
    else $error("rsv");
  a_rd_sixty: assert property (ramp_down_slope_sel[2:1] == 2'b11 |=> ramp_down_rate == 6'h30)
    else $error("rate");
  a_sd_sixty: assert property (shutdown_slope_sel == 3'h7 |=> shutdown_rate == 6'h30)
    else $error("shutdown rate");
  a_ss_sixty: assert property (softstart_slope_sel == 3'h6 |=> softstart_rate == 6'h30)
    else $error("softstart rate");
  a_ru_sixty: assert property (ramp_up_slope_sel == 3'h6 |=> ramp_up_rate == 6'h30)
    else $error("ramp up rate");
  c_w3: cover property (w3);
  c_w5: cover property (w5);
  c_rsv: cover property (reg_rd && reg_addr > 8'h35);
endmodule // bgs_regs_monitor
bind bgs_regs bgs_regs_monitor bgs_regs_monitor_i (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .shutdown_slope_sel(shutdown_slope_sel),
  .softstart_slope_sel(softstart_slope_sel),
  .ramp_down_slope_sel(ramp_down_slope_sel),
  .ramp_up_slope_sel(ramp_up_slope_sel),
  .shutdown_rate(shutdown_rate),
  .softstart_rate(softstart_rate),
  .ramp_down_rate(ramp_down_rate),
  .ramp_up_rate(ramp_up_rate),
  .positive_transient_assist_en(positive_transient_assist_en),
  .negative_transient_assist_en(negative_transient_assist_en)
);

// ---- tb/bgs_regs_tb.sv ----
// Bench for the slope and assist register bank.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`define CHK(v, e) begin compares++; if ((v) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h want %h", $time, v, e); end end
module bgs_regs_tb;
  reg clk_sys = 1'b0, rst_b = 1'b0;
  reg [7:0] q, a, d;
  int errors = 0, compares = 0, cyc = 0, i;
  wire reg_wr, reg_rd, positive_transient_assist_en, negative_transient_assist_en;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire [2:0] shutdown_slope_sel, softstart_slope_sel, ramp_down_slope_sel, ramp_up_slope_sel;
  wire [5:0] shutdown_rate, softstart_rate, ramp_down_rate, ramp_up_rate;
  bgs_regs bgs_regs_i (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .shutdown_slope_sel(shutdown_slope_sel),
    .softstart_slope_sel(softstart_slope_sel),
    .ramp_down_slope_sel(ramp_down_slope_sel),
    .ramp_up_slope_sel(ramp_up_slope_sel),
    .shutdown_rate(shutdown_rate),
    .softstart_rate(softstart_rate),
    .ramp_down_rate(ramp_down_rate),
    .ramp_up_rate(ramp_up_rate),
    .positive_transient_assist_en(positive_transient_assist_en),
    .negative_transient_assist_en(negative_transient_assist_en)
  );
  bgs_host bgs_host_i (
    .clk_sys(clk_sys),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  initial forever #10 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin errors++; summarize; end
  end
  task summarize;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Power-on values
  task t_reset;
    `CHK({shutdown_slope_sel, softstart_slope_sel}, 6'h14)
    `CHK({ramp_down_slope_sel, ramp_up_slope_sel}, 6'h14)
    `CHK({shutdown_rate, softstart_rate}, {6'h04, 6'h10})
    `CHK({ramp_down_rate, ramp_up_rate}, {6'h04, 6'h10})
    `CHK({positive_transient_assist_en, negative_transient_assist_en}, 2'h3)
    bgs_host_i.rd(8'h33, q); `CHK(q, 8'h24)
    bgs_host_i.rd(8'h34, q); `CHK(q, 8'h24)
    bgs_host_i.rd(8'h35, q); `CHK(q, 8'h5F)
  endtask
  // Every code in both slope registers, reserved bits written high
  task t_slopes;
    for (i = 0; i < 8; i++) begin
      d = {1'b0, i[2:0], 1'b0, i[2:0]};
      for (a = 8'h33; a < 8'h35; a++) begin
        bgs_host_i.wr(a, d | 8'h88); bgs_host_i.rd(a, q); `CHK(q, d)
      end
      `CHK({shutdown_slope_sel, softstart_slope_sel, ramp_down_slope_sel}, {3{i[2:0]}})
      `CHK(ramp_up_slope_sel, i[2:0])
      `CHK(ramp_down_rate, (i < 6) ? 6'h01 << i : 6'h30)
      `CHK(shutdown_rate, (i < 6) ? 6'h01 << i : (i == 7) ? 6'h30 : 6'h01)
      `CHK(softstart_rate, (i < 6) ? 6'h01 << i : (i == 6) ? 6'h30 : 6'h01)
      `CHK(ramp_up_rate, (i < 6) ? 6'h01 << i : (i == 6) ? 6'h30 : 6'h01)
    end
  endtask
  // Both assist enables, all four combinations
  task t_assist;
    for (i = 0; i < 4; i++) begin
      bgs_host_i.wr(8'h35, {6'h3F, i[1:0]}); bgs_host_i.rd(8'h35, q);
      `CHK(q, {6'h17, i[1:0]})
      `CHK({positive_transient_assist_en, negative_transient_assist_en}, i[1:0])
    end
  endtask
  // Unmapped places ignore writes and read zero
  task t_reserved;
    bgs_host_i.wr(8'h80, 8'h00); bgs_host_i.rd(8'h80, q); `CHK(q, 8'h00)
    bgs_host_i.rd(8'h34, q); `CHK(q, 8'h77)
    bgs_host_i.rd(8'h35, q); `CHK(q, 8'h5F)
    bgs_host_i.wr(8'h36, 8'hAA); bgs_host_i.rd(8'h36, q); `CHK(q, 8'h00)
    bgs_host_i.wr(8'hFF, 8'h55); bgs_host_i.rd(8'hFF, q); `CHK(q, 8'h00)
    bgs_host_i.rd(8'h33, q); `CHK(q, 8'h77)
  endtask
  // Mid-run reset brings every register and output back to power-on values
  task t_rerst;
    bgs_host_i.wr(8'h35, 8'h00); bgs_host_i.rd(8'h35, q); `CHK(q, 8'h5C)
    `CHK({positive_transient_assist_en, negative_transient_assist_en}, 2'h0)
    @(posedge clk_sys) rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset; t_slopes; t_assist; t_reserved; t_rerst;
    summarize;
  end
endmodule // bgs_regs_tb
